/* scc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scc_cfg.svh"
module scc_top import scc_pkg::*; (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic arst_n,
    // Card and link options.
    input wire scc_card_t card_variant,
    input wire logic e1_mode,
    input wire logic e1_sig_cas_ccs,
    // Edit port.
    input wire logic edit_we,
    input wire logic [`SCC_PORT_W-1:0] edit_port,
    input wire scc_port_cfg_t edit_cfg,
    // Commit and discard.
    input wire logic commit_req,
    input wire logic [`SCC_PORT_W-1:0] commit_port,
    input wire logic discard_req,
    // Readback select.
    input wire logic [`SCC_PORT_W-1:0] rd_port,
    // Commit result.
    output logic commit_done_q,
    output logic commit_ok_q,
    output scc_err_t commit_err_q,
    // Readback.
    output scc_port_cfg_t rd_live_q,
    output scc_port_cfg_t rd_pend_q,
    output logic [`SCC_NSEG_MAX-1:0] rd_mask_q
);
    localparam int NP = `SCC_NUM_PORTS;

    // ****************************************************************
    // Storage: pending edits and committed settings per port.
    // ****************************************************************
    scc_port_cfg_t pend_q [NP];
    scc_port_cfg_t live_q [NP];
    scc_port_cfg_t edit_norm;
    scc_port_cfg_t cand;
    logic [`SCC_NSEG_MAX-1:0] live_mask [NP];
    logic [`SCC_NSEG_MAX-1:0] cand_mask;
    logic cand_overrun;
    logic [NP-1:0] conflict;
    logic [`SCC_PORT_W-1:0] port_lim;
    logic edit_ok;
    logic cport_ok;
    logic [`SCC_PORT_W-1:0] cidx;
    logic [`SCC_PORT_W-1:0] ridx;
    scc_err_t chk_err;
    scc_err_t errs;
    logic commit_go;

    // ****************************************************************
    // Decode.
    // ****************************************************************

    // The card variant decides how many ports exist at all.
    assign port_lim = (card_variant == SCC_CARD_TWO) ? `SCC_PORTS_TWO :
                      (card_variant == SCC_CARD_FIVE) ? `SCC_PORTS_FIVE : `SCC_PORTS_TEN;
    assign edit_ok = edit_we && (edit_port < port_lim);
    assign cport_ok = commit_port < port_lim;
    // Out-of-range indices fall back to port 0 so no array read goes wild.
    assign cidx = cport_ok ? commit_port : '0;
    assign ridx = (rd_port < port_lim) ? rd_port : '0;
    assign cand = pend_q[cidx];

    // Single-channel framing owns only index 1, so the edit forces it.
    always_comb begin
        edit_norm = edit_cfg;
        if (edit_cfg.frame == SCC_FR_A) begin
            edit_norm.subrate_segment_index = 5'h01;
        end
    end

    // ****************************************************************
    // Segment maps and checks.
    // ****************************************************************

    // Candidate from the pending table.
    scc_seg_mask u_cand_mask (
        .cfg(cand),
        .mask(cand_mask),
        .overrun(cand_overrun)
    );

    scc_cfg_check u_check (
        .cfg(cand),
        .overrun(cand_overrun),
        .card_variant(card_variant),
        .e1_mode(e1_mode),
        .e1_sig_cas_ccs(e1_sig_cas_ccs),
        .err(chk_err)
    );

    // Each live port's occupied segments, and whether it collides with the candidate.
    // Two ports share a frame when destination and timeslot match; a framing
    // mismatch on a shared slot can never coexist, so it counts as overlap.
    for (genvar j = 0; j < NP; j++) begin : g_port
        scc_seg_mask u_live_mask (
            .cfg(live_q[j]),
            .mask(live_mask[j]),
            .overrun()
        );
        assign conflict[j] = (cidx != `SCC_PORT_W'(j)) &&
                             live_q[j].active && cand.active &&
                             (live_q[j].destination_select == cand.destination_select) &&
                             (live_q[j].dest_num == cand.dest_num) &&
                             (live_q[j].wan_timeslot == cand.wan_timeslot) &&
                             ((live_q[j].frame != cand.frame) ||
                              (|(live_mask[j] & cand_mask)));
    end

    // Merge every reason for refusal.
    always_comb begin
        errs = chk_err;
        errs.range_err = chk_err.range_err || !cport_ok;
        errs.overlap = |conflict;
    end

    // Only a clean candidate is applied; a discard in the same cycle wins.
    assign commit_go = commit_req && !discard_req && (errs == '0);

    // ****************************************************************
    // Pending table.
    // ****************************************************************

    // Edits land here only; discard copies the committed table back.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NP; i++) begin
                pend_q[i] <= SCC_PORT_DEFAULT;
            end
        end else if (discard_req) begin
            for (int i = 0; i < NP; i++) begin
                pend_q[i] <= live_q[i];
            end
        end else if (edit_ok) begin
            pend_q[edit_port] <= edit_norm;
        end
    end

    // ****************************************************************
    // Live table.
    // ****************************************************************

    // A refused commit leaves the previous assignment in force.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NP; i++) begin
                live_q[i] <= SCC_PORT_DEFAULT;
            end
        end else if (commit_go) begin
            live_q[cidx] <= cand;
        end
    end

    // ****************************************************************
    // Status and readback.
    // ****************************************************************

    // Result of a commit appears one cycle after the request.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            commit_done_q <= 1'b0;
            commit_ok_q <= 1'b0;
            commit_err_q <= '0;
        end else begin
            commit_done_q <= commit_req;
            commit_ok_q <= commit_go;
            if (commit_req) begin
                commit_err_q <= errs;
            end
        end
    end

    // Readback lags the select by one cycle.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_live_q <= SCC_PORT_DEFAULT;
            rd_pend_q <= SCC_PORT_DEFAULT;
            rd_mask_q <= '0;
        end else begin
            rd_live_q <= live_q[ridx];
            rd_pend_q <= pend_q[ridx];
            rd_mask_q <= live_mask[ridx];
        end
    end

    // ****************************************************************
    // Checks on the design's own behaviour.
    // ****************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_rejected;
        commit_done_q && !commit_ok_q;
    endsequence

    sequence s_srv_low_rate;
        commit_req && cand.destination_select &&
        !(cand.rate == SCC_R_56K || cand.rate == SCC_R_64K);
    endsequence

    AST_IDLE_NO_SEG: assert property (!cand.active |-> cand_mask == '0)
        else $error("idle port holds segments");
    AST_SRV_RATE: assert property (s_srv_low_rate |=> s_rejected and commit_err_q.rate_err)
        else $error("server port accepted a low rate");
    AST_TS_ZERO: assert property (commit_req && cand.wan_timeslot == 5'h00 |=> s_rejected)
        else $error("timeslot zero accepted");
    AST_E1_SIG: assert property (commit_req && e1_mode && e1_sig_cas_ccs &&
            cand.wan_timeslot == 5'h10 |=> commit_err_q.range_err)
        else $error("E1 slot 16 accepted under signalling");
    AST_OVERRUN: assert property (commit_req && cand.active && cand.frame == SCC_FR_B5 &&
            cand.rate == SCC_R_19K2 && cand.subrate_segment_index == 5'h05
            |=> s_rejected and commit_err_q.invalid_seg)
        else $error("19.2 at last segment accepted");
    AST_OVERLAP: assert property (commit_req && |conflict |=> s_rejected and commit_err_q.overlap)
        else $error("overlapping segments accepted");
    AST_MAJV: assert property (commit_req && cand.error_correction_select == SCC_EC_MAJV &&
            cand.rate > SCC_R_9K6 |=> s_rejected)
        else $error("majority vote accepted above 9.6");
    AST_SW56_ECC: assert property (commit_req && cand.rate == SCC_R_SW56 &&
            cand.error_correction_select != SCC_EC_OFF |=> commit_err_q.ecc_err)
        else $error("correction accepted at switched 56");
    AST_BCH_CARD: assert property (commit_req && card_variant != SCC_CARD_TWO &&
            cand.error_correction_select == SCC_EC_BCH |=> s_rejected)
        else $error("BCH accepted on a multi-port card");
    AST_HOLD_LIVE: assert property (commit_req && !commit_go
            |=> live_q[$past(cidx)] == $past(live_q[cidx]))
        else $error("refused commit changed live settings");
    AST_DISCARD: assert property (discard_req |=> pend_q[0] == $past(live_q[0]))
        else $error("discard did not restore port 0");
    AST_FORCE_IDX: assert property (edit_ok && edit_cfg.frame == SCC_FR_A
            && !discard_req |=> pend_q[$past(edit_port)].subrate_segment_index == 5'h01)
        else $error("single-channel index not forced to 1");
endmodule
`default_nettype wire

/* scc_cfg.svh */
// Function
// - Inactive port claims no segment or slot.
// - Destination steers to WAN or server port.
// - Timeslot range per link; E1 signalling skips 16.
// - Server destination accepts only 56K or 64K.
// - Four framings: single channel, 5/10/20 segments.
// - Rate is one of seven coded rates.
// - Segment index range follows framing; single forces 1.
// - Faster circuits take several adjacent segments.
// - Chosen index is the circuit's first segment.
// - Segments past frame end give invalid-slot error.
// - Segment held by another circuit gives overlap.
// - Majority vote only at 2.4, 4.8, 9.6.
// - No correction at switched 56 rate.
// - BCH only 19.2/56/64 and two-port card.
// - Only two-port card offers far-end line mode.
// - Reset loads documented default settings.
// - Edits stay pending until commit; discard restores.
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

// ****************************************************************
// Sizes of the port table and the sub-rate frame.
// ****************************************************************
`define SCC_NUM_PORTS 10
`define SCC_PORT_W 4
`define SCC_NSEG_MAX 20
`define SCC_PORTS_TWO 4'h2
`define SCC_PORTS_FIVE 4'h5
`define SCC_PORTS_TEN 4'hA
`define SCC_NSEG_B5 5'h05
`define SCC_NSEG_B10 5'h0A
`define SCC_NSEG_B20 5'h14
`define SCC_SHIFT_B5 3'h2
`define SCC_SHIFT_B10 3'h1
`define SCC_SHIFT_B20 3'h0

// ****************************************************************
// Timeslot and destination limits.
// ****************************************************************
`define SCC_TS_MAX_T1 5'h18
`define SCC_TS_MAX_E1 5'h1F
`define SCC_TS_E1_SIG 5'h10
`define SCC_SRV_PORTS 3'h3

// ****************************************************************
// Reset values of a port's settings.
// ****************************************************************
`define SCC_RST_TS 5'h01
`define SCC_RST_SEG 5'h01
`define SCC_RST_DEST 3'h0

`endif

/* scc_pkg.sv */
`include "scc_cfg.svh"
package scc_pkg;
    // ****************************************************************
    // Setting encodings.
    // ****************************************************************
    typedef enum logic [1:0] {SCC_FR_A, SCC_FR_B5, SCC_FR_B10, SCC_FR_B20} scc_frame_t;
    typedef enum logic [2:0] {
        SCC_R_2K4, SCC_R_4K8, SCC_R_9K6, SCC_R_19K2, SCC_R_56K, SCC_R_64K, SCC_R_SW56
    } scc_rate_t;
    typedef enum logic [1:0] {SCC_EC_OFF, SCC_EC_MAJV, SCC_EC_BCH} scc_ecc_t;
    typedef enum logic [1:0] {SCC_DETECT_WITH_TIMEOUT, SCC_LD_ON, SCC_LD_OFF} scc_lbdet_t;
    typedef enum logic [1:0] {SCC_CARD_TWO, SCC_CARD_FIVE, SCC_CARD_TEN} scc_card_t;

    // One port's settings; destination_select is 1 for a server port.
    typedef struct packed {
        logic active;
        logic destination_select;
        logic [2:0] dest_num;
        logic [4:0] wan_timeslot;
        scc_frame_t frame;
        scc_rate_t rate;
        logic [4:0] subrate_segment_index;
        logic line_mode_far;
        scc_ecc_t error_correction_select;
        logic secondary_on;
        logic local_loopback_on;
        scc_lbdet_t loopback_detect_select;
    } scc_port_cfg_t;

    // Reasons a commit was refused.
    typedef struct packed {
        logic range_err;
        logic rate_err;
        logic frame_err;
        logic ecc_err;
        logic invalid_seg;
        logic overlap;
    } scc_err_t;

    localparam scc_port_cfg_t SCC_PORT_DEFAULT = '{
        active: 1'b0, destination_select: 1'b0, dest_num: `SCC_RST_DEST,
        wan_timeslot: `SCC_RST_TS, frame: SCC_FR_A, rate: SCC_R_2K4,
        subrate_segment_index: `SCC_RST_SEG, line_mode_far: 1'b0,
        error_correction_select: SCC_EC_OFF, secondary_on: 1'b0,
        local_loopback_on: 1'b0, loopback_detect_select: SCC_DETECT_WITH_TIMEOUT
    };
endpackage

/* scc_seg_mask.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scc_cfg.svh"
module scc_seg_mask import scc_pkg::*; (
    // Port settings in.
    input wire scc_port_cfg_t cfg,
    // Occupied segments and overrun flag out.
    output logic [`SCC_NSEG_MAX-1:0] mask,
    output logic overrun
);
    logic [2:0] shift;
    logic [4:0] nseg;
    logic [2:0] need_log;
    logic [4:0] need;
    logic [4:0] start;
    logic [5:0] last;

    // Segment size follows the framing; each rate step up from the segment's own rate doubles the span.
    always_comb begin
        case (cfg.frame)
            SCC_FR_B5: begin shift = `SCC_SHIFT_B5; nseg = `SCC_NSEG_B5; end
            SCC_FR_B10: begin shift = `SCC_SHIFT_B10; nseg = `SCC_NSEG_B10; end
            SCC_FR_B20: begin shift = `SCC_SHIFT_B20; nseg = `SCC_NSEG_B20; end
            default: begin shift = 3'h0; nseg = 5'h01; end
        endcase
    end

    // A 19.2 circuit in 5-segment framing needs two segments.
    assign need_log = (cfg.rate > shift) ? 3'(cfg.rate - shift) : 3'h0;
    assign need = 5'(5'h01 << need_log);
    // The chosen index is the first segment; the rest follow upward.
    assign start = cfg.subrate_segment_index - 5'h01;
    assign last = {1'b0, start} + {1'b0, need};
    // Running past the frame's last segment is refused.
    assign overrun = (cfg.frame != SCC_FR_A) &&
                     (cfg.subrate_segment_index == 5'h00 || last > {1'b0, nseg});

    // An idle port holds nothing; single-channel framing holds the whole slot.
    always_comb begin
        if (!cfg.active) begin
            mask = '0;
        end else if (cfg.frame == SCC_FR_A) begin
            mask = '1;
        end else begin
            mask = ((20'h0_0001 << need) - 20'h0_0001) << start;
        end
    end
endmodule
`default_nettype wire

/* scc_cfg_check.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scc_cfg.svh"
module scc_cfg_check import scc_pkg::*; (
    // Settings under test.
    input wire scc_port_cfg_t cfg,
    input wire logic overrun,
    // Card and link options.
    input wire scc_card_t card_variant,
    input wire logic e1_mode,
    input wire logic e1_sig_cas_ccs,
    // Result; overlap is judged by the caller.
    output scc_err_t err
);
    logic ts_bad;
    logic dest_bad;
    logic rate_fast;
    logic two_port;

    assign two_port = (card_variant == SCC_CARD_TWO);
    // Server ports P1..P3 only; any of the eight WAN ports is legal.
    assign dest_bad = cfg.destination_select && (cfg.dest_num >= `SCC_SRV_PORTS);
    // Slot 0 never exists; E1 loses slot 16 under channel signalling.
    assign ts_bad = (cfg.wan_timeslot == 5'h00) ||
                    (!e1_mode && cfg.wan_timeslot > `SCC_TS_MAX_T1) ||
                    (e1_mode && e1_sig_cas_ccs && cfg.wan_timeslot == `SCC_TS_E1_SIG);
    assign rate_fast = (cfg.rate >= SCC_R_56K);

    // All checks are combinational so a commit resolves in one cycle.
    always_comb begin
        err = '0;
        err.range_err = dest_bad || ts_bad ||
                        (cfg.line_mode_far && !two_port);
        // Unused rate code, or a server fed below 56K or with switched 56.
        err.rate_err = (cfg.rate > SCC_R_SW56) ||
                       (cfg.destination_select &&
                        !(cfg.rate == SCC_R_56K || cfg.rate == SCC_R_64K));
        // Sub-rate framings carry nothing faster than 19.2.
        err.frame_err = (cfg.frame != SCC_FR_A) && rate_fast;
        err.ecc_err = (cfg.error_correction_select == SCC_EC_MAJV && cfg.rate > SCC_R_9K6) ||
                      (cfg.rate == SCC_R_SW56 &&
                       cfg.error_correction_select != SCC_EC_OFF) ||
                      (cfg.error_correction_select == SCC_EC_BCH &&
                       (!two_port || cfg.rate < SCC_R_19K2 || cfg.rate == SCC_R_SW56)) ||
                      (cfg.error_correction_select > SCC_EC_BCH);
        err.invalid_seg = overrun;
    end
endmodule
`default_nettype wire

/* subrate_slot_config_checker_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scc_cfg.svh"
module subrate_slot_config_checker_test import scc_pkg::*;;
    // ****************************************************************
    // Stimulus and observation signals.
    // ****************************************************************
    logic core_clk;
    logic arst_n;
    scc_card_t card_variant;
    logic e1_mode;
    logic e1_sig_cas_ccs;
    logic edit_we;
    logic [`SCC_PORT_W-1:0] edit_port;
    scc_port_cfg_t edit_cfg;
    logic commit_req;
    logic [`SCC_PORT_W-1:0] commit_port;
    logic discard_req;
    logic [`SCC_PORT_W-1:0] rd_port;
    logic commit_done_q;
    logic commit_ok_q;
    scc_err_t commit_err_q;
    scc_port_cfg_t rd_live_q;
    scc_port_cfg_t rd_pend_q;
    logic [`SCC_NSEG_MAX-1:0] rd_mask_q;
    int n_errors;
    int checked;
    logic [31:0] seed;
    scc_port_cfg_t c;
    scc_rate_t rt;
    scc_ecc_t ec;
    logic bad;

    scc_top dut_u (
        .core_clk(core_clk), .arst_n(arst_n), .card_variant(card_variant),
        .e1_mode(e1_mode), .e1_sig_cas_ccs(e1_sig_cas_ccs), .edit_we(edit_we),
        .edit_port(edit_port), .edit_cfg(edit_cfg), .commit_req(commit_req),
        .commit_port(commit_port), .discard_req(discard_req), .rd_port(rd_port),
        .commit_done_q(commit_done_q), .commit_ok_q(commit_ok_q),
        .commit_err_q(commit_err_q), .rd_live_q(rd_live_q), .rd_pend_q(rd_pend_q),
        .rd_mask_q(rd_mask_q)
    );

    // ****************************************************************
    // Helpers: random source, expectations and bus tasks.
    // ****************************************************************
    // Free-running 20 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Builds a setting from the defaults so untouched fields stay at reset values.
    function automatic scc_port_cfg_t mk(input logic act, input logic srv,
        input logic [2:0] dn, input logic [4:0] ts, input scc_frame_t fr,
        input scc_rate_t r, input logic [4:0] ix, input scc_ecc_t e);
        scc_port_cfg_t k;
        k = SCC_PORT_DEFAULT;
        k.active = act;
        k.destination_select = srv;
        k.dest_num = dn;
        k.wan_timeslot = ts;
        k.frame = fr;
        k.rate = r;
        k.subrate_segment_index = ix;
        k.error_correction_select = e;
        return k;
    endfunction

    // Correction is legal only for the rate and card pairs that allow it.
    function automatic logic ecc_bad(input scc_rate_t r, input scc_ecc_t e, input scc_card_t k);
        if (e == SCC_EC_MAJV) begin
            return r > SCC_R_9K6;
        end
        if (e == SCC_EC_BCH) begin
            return !(r inside {SCC_R_19K2, SCC_R_56K, SCC_R_64K}) || k != SCC_CARD_TWO;
        end
        return 1'b0;
    endfunction

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic ed(input logic [3:0] p, input scc_port_cfg_t v);
        @(posedge core_clk);
        edit_we <= 1'b1;
        edit_port <= p;
        edit_cfg <= v;
        @(posedge core_clk);
        edit_we <= 1'b0;
    endtask

    // Result is registered one cycle after the request is taken.
    task automatic cm(input logic [3:0] p, input logic [5:0] ee, input logic eo);
        @(posedge core_clk);
        commit_req <= 1'b1;
        commit_port <= p;
        @(posedge core_clk);
        commit_req <= 1'b0;
        #1;
        chk(commit_done_q, 1);
        chk(commit_err_q, ee);
        chk(commit_ok_q, eo);
        // The done pulse stands for one cycle only.
        @(posedge core_clk);
        #1;
        chk(commit_done_q, 0);
    endtask

    task automatic edcm(input logic [3:0] p, input scc_port_cfg_t v, input logic [5:0] ee);
        ed(p, v);
        cm(p, ee, ee == 6'h00);
    endtask

    // Readback lags the select by one register stage.
    task automatic rb(input logic [3:0] p);
        @(posedge core_clk);
        rd_port <= p;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic give_verdict;
        if (n_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog: a hang counts as a failure.
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        give_verdict();
    end

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        n_errors = 0;
        checked = 0;
        seed = 32'hb2a6_98c1;
        arst_n = 1'b0;
        card_variant = SCC_CARD_TEN;
        e1_mode = 1'b0;
        e1_sig_cas_ccs = 1'b0;
        edit_we = 1'b0;
        edit_port = 4'h0;
        edit_cfg = SCC_PORT_DEFAULT;
        commit_req = 1'b0;
        commit_port = 4'h0;
        discard_req = 1'b0;
        rd_port = 4'h0;
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        rb(4'h3);
        chk(rd_live_q, SCC_PORT_DEFAULT);
        chk(rd_pend_q, SCC_PORT_DEFAULT);
        chk(rd_mask_q, 20'h0_0000);
        // A 19.2 circuit in five segments takes the chosen index and the next one.
        edcm(4'h0, mk(1, 0, 3'h0, 5'h01, SCC_FR_B5, SCC_R_19K2, 5'h01, SCC_EC_OFF), 6'h00);
        rb(4'h0);
        chk(rd_mask_q, 20'h0_0003);
        edcm(4'h1, mk(1, 0, 3'h0, 5'h01, SCC_FR_B5, SCC_R_9K6, 5'h02, SCC_EC_OFF), 6'h01);
        edcm(4'h1, mk(1, 0, 3'h0, 5'h01, SCC_FR_B5, SCC_R_9K6, 5'h03, SCC_EC_OFF), 6'h00);
        rb(4'h1);
        chk(rd_mask_q, 20'h0_0004);
        edcm(4'h2, mk(1, 0, 3'h0, 5'h01, SCC_FR_B5, SCC_R_9K6, 5'h03, SCC_EC_OFF), 6'h01);
        edcm(4'h2, mk(1, 0, 3'h0, 5'h02, SCC_FR_B5, SCC_R_19K2, 5'h05, SCC_EC_OFF), 6'h02);
        rb(4'h2);
        chk(rd_live_q, SCC_PORT_DEFAULT);
        chk(rd_mask_q, 20'h0_0000);
        // Range, destination, framing and index limits on ports 3 to 6.
        edcm(4'h3, mk(1, 1, 3'h0, 5'h05, SCC_FR_A, SCC_R_9K6, 5'h01, SCC_EC_OFF), 6'h10);
        edcm(4'h3, mk(1, 1, 3'h3, 5'h05, SCC_FR_A, SCC_R_64K, 5'h01, SCC_EC_OFF), 6'h20);
        edcm(4'h3, mk(1, 1, 3'h2, 5'h05, SCC_FR_A, SCC_R_56K, 5'h01, SCC_EC_OFF), 6'h00);
        rb(4'h3);
        chk(rd_mask_q, 20'hF_FFFF);
        edcm(4'h4, mk(0, 0, 3'h7, 5'h19, SCC_FR_A, SCC_R_2K4, 5'h01, SCC_EC_OFF), 6'h20);
        edcm(4'h4, mk(0, 0, 3'h7, 5'h18, SCC_FR_A, SCC_R_2K4, 5'h01, SCC_EC_OFF), 6'h00);
        rb(4'h4);
        chk(rd_mask_q, 20'h0_0000);
        e1_mode <= 1'b1;
        edcm(4'h4, mk(0, 0, 3'h0, 5'h1F, SCC_FR_A, SCC_R_2K4, 5'h01, SCC_EC_OFF), 6'h00);
        e1_sig_cas_ccs <= 1'b1;
        edcm(4'h4, mk(0, 0, 3'h0, 5'h10, SCC_FR_A, SCC_R_2K4, 5'h01, SCC_EC_OFF), 6'h20);
        edcm(4'h5, mk(0, 0, 3'h0, 5'h02, SCC_FR_B10, SCC_R_56K, 5'h01, SCC_EC_OFF), 6'h08);
        edcm(4'h5, mk(0, 0, 3'h0, 5'h02, SCC_FR_B5, SCC_R_2K4, 5'h06, SCC_EC_OFF), 6'h02);
        edcm(4'h5, mk(0, 0, 3'h0, 5'h02, SCC_FR_B20, SCC_R_2K4, 5'h14, SCC_EC_OFF), 6'h00);
        ed(4'h6, mk(0, 0, 3'h0, 5'h02, SCC_FR_A, SCC_R_2K4, 5'h07, SCC_EC_OFF));
        rb(4'h6);
        chk(rd_pend_q.subrate_segment_index, 5'h01);
        // Pending edits are dropped by a discard.
        ed(4'h0, mk(1, 0, 3'h0, 5'h01, SCC_FR_B5, SCC_R_9K6, 5'h01, SCC_EC_OFF));
        rb(4'h0);
        chk(rd_pend_q.rate, SCC_R_9K6);
        chk(rd_live_q.rate, SCC_R_19K2);
        @(posedge core_clk);
        discard_req <= 1'b1;
        @(posedge core_clk);
        discard_req <= 1'b0;
        rb(4'h0);
        c = mk(1, 0, 3'h0, 5'h01, SCC_FR_B5, SCC_R_19K2, 5'h01, SCC_EC_OFF);
        chk(rd_pend_q, c);
        chk(rd_live_q, c);
        card_variant <= SCC_CARD_FIVE;
        edcm(4'h1, mk(1, 0, 3'h0, 5'h14, SCC_FR_A, SCC_R_19K2, 5'h01, SCC_EC_BCH), 6'h04);
        c = mk(0, 0, 3'h0, 5'h14, SCC_FR_A, SCC_R_2K4, 5'h01, SCC_EC_OFF);
        c.line_mode_far = 1'b1;
        edcm(4'h1, c, 6'h20);
        // Random rate and correction pairs on the two-port card.
        card_variant <= SCC_CARD_TWO;
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            rt = scc_rate_t'(seed[2:0] % 3'h7);
            ec = scc_ecc_t'(seed[4:3] % 2'h3);
            bad = ecc_bad(rt, ec, SCC_CARD_TWO);
            edcm(4'h1, mk(1, 0, 3'h1, 5'h14, SCC_FR_A, rt, 5'h01, ec), {3'b000, bad, 2'b00});
        end
        // Unused rate and correction codes are refused.
        c = mk(1, 0, 3'h1, 5'h14, SCC_FR_A, scc_rate_t'(3'h7), 5'h01, SCC_EC_OFF);
        edcm(4'h1, c, 6'h10);
        c = mk(1, 0, 3'h1, 5'h14, SCC_FR_A, SCC_R_2K4, 5'h01, scc_ecc_t'(2'h3));
        edcm(4'h1, c, 6'h04);
        give_verdict();
    end
endmodule
`default_nettype wire
